// [src/iqu_pkg.sv]
package iqu_pkg;
    localparam int          IQU_BYTE_W      = 8;
    localparam int          IQU_WORD_W      = 16;
    localparam int          IQU_AMP_W       = 14;
    localparam int          IQU_MARK1_BIT   = 14;
    localparam int          IQU_MARK2_BIT   = 15;
    localparam int          IQU_FIFO_DEPTH  = 8;
    localparam logic [13:0] IQU_CODE_NEG_FS = 14'h0000;
    localparam logic [13:0] IQU_CODE_ZERO   = 14'h2000;
    localparam logic [13:0] IQU_CODE_POS_FS = 14'h3fff;
    localparam logic [13:0] IQU_AMP_RESET   = IQU_CODE_ZERO;
    localparam logic [1:0]  IQU_MARK_RESET  = 2'h0;

    typedef enum logic [1:0]
    {
        IQU_ST_I_HI = 2'b00,
        IQU_ST_I_LO = 2'b01,
        IQU_ST_Q_HI = 2'b10,
        IQU_ST_Q_LO = 2'b11
    } iqu_state_t;
endpackage

// [src/iqu_fifo.sv]
`timescale 1ns/100ps
module iqu_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// [src/iqu_unpacker.sv]
// Notes on behaviour
// [RL1] Each I and Q sample is two bytes, high byte first.
// [RL2] Converter gets only the low fourteen bits of each word.
// [RL3] I bit 14 is marker one, bit 15 marker two; Q upper bits reserved.
// [RL4] Marker output is high exactly while its I word bit is one.
// [RL5] Amplitude is offset binary; 0 negative, 8192 zero, 16383 positive.
// [RL6] Host rewrites both I and Q arrays when replacing a waveform.
// [RL7] Host keeps amplitude values at or below 16383.
// [RL8] Host supplies at least sixteen, and an even number of, points.
// [RL9] A channel that is not supplied plays the zero-output code.
// [RL10] I, Q amplitudes and markers are registered together on each sample pop, held otherwise.
`timescale 1ns/100ps
module iqu_unpacker
    import iqu_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic [IQU_BYTE_W-1:0] byte_data,
    input  wire logic                 byte_valid,
    output logic                      byte_ready,
    input  wire logic                 i_present,
    input  wire logic                 q_present,
    input  wire logic                 sample_ready,
    output logic                      sample_strobe,
    output logic      [IQU_AMP_W-1:0] dac_i,
    output logic      [IQU_AMP_W-1:0] dac_q,
    output logic                      marker1,
    output logic                      marker2
);
    iqu_state_t            state_reg;
    iqu_state_t            state_next;
    logic [IQU_BYTE_W-1:0] i_hi_reg;
    logic [IQU_BYTE_W-1:0] i_lo_reg;
    logic [IQU_BYTE_W-1:0] q_hi_reg;

    // Byte pair to word, high byte first
    function automatic logic [IQU_WORD_W-1:0] word_of
    (
        input logic [IQU_BYTE_W-1:0] hi,
        input logic [IQU_BYTE_W-1:0] lo
    );
        word_of = {hi, lo};
    endfunction

    function automatic logic [IQU_AMP_W-1:0] amp_of
    (
        input logic [IQU_WORD_W-1:0] word
    );
        amp_of = word[IQU_AMP_W-1:0];
    endfunction

    function automatic logic [1:0] marks_of
    (
        input logic [IQU_WORD_W-1:0] word
    );
        marks_of = {word[IQU_MARK2_BIT], word[IQU_MARK1_BIT]};
    endfunction

    // Absent channel skips its bytes entirely, except I when Q is also absent
    wire                  need_i    = i_present || !q_present;
    wire                  take_byte = byte_valid && byte_ready;
    wire [IQU_WORD_W-1:0] i_word    = word_of(i_hi_reg, i_lo_reg);      // RL1
    wire [IQU_WORD_W-1:0] q_word    = word_of(q_hi_reg, byte_data);     // RL1
    // I-only sample closes on its low byte, before that byte is stored
    wire [IQU_WORD_W-1:0] i_word_q  = word_of(i_hi_reg, byte_data);     // RL1

    wire [31:0]           fifo_in;
    wire                  fifo_in_valid;
    wire                  fifo_in_ready;
    wire [31:0]           fifo_out;
    wire                  fifo_out_valid;
    wire                  last_i    = (state_reg == IQU_ST_I_LO) && !q_present;
    wire                  last_q    = (state_reg == IQU_ST_Q_LO);
    wire                  word_done = take_byte && (last_i || last_q);
    wire [IQU_WORD_W-1:0] i_src     = last_i ? i_word_q : i_word;

    // Zero-output code stands in for a missing channel
    wire [IQU_AMP_W-1:0]  i_amp = i_present ? amp_of(i_src) : IQU_CODE_ZERO;   // RL2 RL5 RL9
    wire [1:0]            i_mk  = i_present ? marks_of(i_src) : 2'h0;          // RL3
    // Reserved Q bits 15:14 never leave this point
    wire [IQU_AMP_W-1:0]  q_amp = q_present ? amp_of(q_word) : IQU_CODE_ZERO;  // RL2 RL3 RL9

    assign fifo_in       = {i_mk, i_amp, 2'h0, q_amp};
    assign fifo_in_valid = word_done;
    // Stall byte intake while the sample buffer is full
    assign byte_ready    = fifo_in_ready;

    always_comb
    begin
        state_next = state_reg;
        if (take_byte)
        begin
            unique case (state_reg)
                IQU_ST_I_HI: state_next = IQU_ST_I_LO;
                IQU_ST_I_LO: state_next = q_present ? IQU_ST_Q_HI : IQU_ST_I_HI;
                IQU_ST_Q_HI: state_next = IQU_ST_Q_LO;
                IQU_ST_Q_LO: state_next = need_i ? IQU_ST_I_HI : IQU_ST_Q_HI;
            endcase
        end
        else if (state_reg == IQU_ST_I_HI && !need_i)
            state_next = IQU_ST_Q_HI;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= IQU_ST_I_HI;
            i_hi_reg  <= '0;
            i_lo_reg  <= '0;
            q_hi_reg  <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (take_byte && state_reg == IQU_ST_I_HI)
                i_hi_reg <= byte_data;                              // RL1
            if (take_byte && state_reg == IQU_ST_I_LO)
                i_lo_reg <= byte_data;
            if (take_byte && state_reg == IQU_ST_Q_HI)
                q_hi_reg <= byte_data;
        end
    end

    iqu_fifo #(
        .WIDTH (32),
        .DEPTH (IQU_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (sample_ready)
    );

    wire pop = fifo_out_valid && sample_ready;

    // One register stage keeps markers aligned with their sample
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dac_i         <= IQU_AMP_RESET;                         // RL5
            dac_q         <= IQU_AMP_RESET;                         // RL5
            marker1       <= IQU_MARK_RESET[0];
            marker2       <= IQU_MARK_RESET[1];
            sample_strobe <= 1'h0;
        end
        else
        begin
            sample_strobe <= pop;                                   // RL10
            if (pop)
            begin
                dac_i   <= fifo_out[29:16];                         // RL2 RL5 RL10
                dac_q   <= fifo_out[13:0];                          // RL2 RL10
                marker1 <= fifo_out[16+IQU_MARK1_BIT];              // RL3 RL4
                marker2 <= fifo_out[16+IQU_MARK2_BIT];              // RL3 RL4
            end
        end
    end

    a_marker_follows: assert property (@(posedge clk_sys) disable iff (rst) // RL4
        pop |=> (marker1 == $past(fifo_out[30]) && marker2 == $past(fifo_out[31])))
        else $error("Marker does not follow I word bits");

    a_amp_low_bits: assert property (@(posedge clk_sys) disable iff (rst) // RL2
        pop |=> (dac_i == $past(fifo_out[29:16]) && dac_q == $past(fifo_out[13:0])))
        else $error("Amplitude not taken from low bits");

    a_missing_zero: assert property (@(posedge clk_sys) disable iff (rst) // RL9
        (word_done && !i_present) |-> fifo_in[31:16] == {2'h0, IQU_CODE_ZERO})
        else $error("Missing I channel not zero code");

    a_missing_zero_q: assert property (@(posedge clk_sys) disable iff (rst) // RL9
        (word_done && !q_present) |-> fifo_in[13:0] == IQU_CODE_ZERO)
        else $error("Missing Q channel not zero code");

    a_marker_from_i: assert property (@(posedge clk_sys) disable iff (rst) // RL3
        (word_done && i_present) |-> fifo_in[31:30] == i_hi_reg[7:6])
        else $error("Marker bits not taken from the I word");

    a_q_reserved_drop: assert property (@(posedge clk_sys) disable iff (rst) // RL3
        (word_done && q_present) |-> fifo_in[15:0] == {2'h0, q_hi_reg[5:0], byte_data})
        else $error("Reserved Q bits reached the sample");

    sequence s_i_pair;
        take_byte && state_reg == IQU_ST_I_HI ##1 take_byte && state_reg == IQU_ST_I_LO;
    endsequence

    sequence s_q_pair;
        take_byte && state_reg == IQU_ST_Q_HI ##1 take_byte && state_reg == IQU_ST_Q_LO;
    endsequence

    a_byte_order: assert property (@(posedge clk_sys) disable iff (rst) // RL1
        (take_byte && state_reg == IQU_ST_I_HI) |=> i_hi_reg == $past(byte_data))
        else $error("High byte not stored first");

    a_q_byte_order: assert property (@(posedge clk_sys) disable iff (rst) // RL1
        (take_byte && state_reg == IQU_ST_Q_HI) |=> q_hi_reg == $past(byte_data))
        else $error("Q high byte not stored first");

    a_pair_pushes: assert property (@(posedge clk_sys) disable iff (rst) // RL1
        (s_i_pair ##0 !q_present) |-> word_done)
        else $error("I pair did not complete a word");

    a_q_pair_pushes: assert property (@(posedge clk_sys) disable iff (rst) // RL1
        s_q_pair |-> word_done)
        else $error("Q pair did not complete a word");

    a_skip_absent_i: assert property (@(posedge clk_sys) disable iff (rst) // RL9
        (state_reg == IQU_ST_I_HI && !need_i && !take_byte) |=> state_reg == IQU_ST_Q_HI)
        else $error("Absent I channel not skipped");

    a_hold_idle: assert property (@(posedge clk_sys) disable iff (rst) // RL10
        !pop |=> $stable(dac_i) && $stable(dac_q) && $stable(marker1) && $stable(marker2))
        else $error("Outputs changed without a sample");

    a_strobe_pulse: assert property (@(posedge clk_sys) disable iff (rst) // RL10
        pop |=> sample_strobe)
        else $error("Strobe missing after sample");

    a_strobe_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RL10
        !pop |=> !sample_strobe)
        else $error("Strobe without a sample");
endmodule

// [verification/iqu_host_model.sv]
`timescale 1ns/100ps
module iqu_host_model
(
    input  wire logic       clk_sys,
    input  wire logic       byte_ready,
    input  wire logic       use_i,
    input  wire logic       use_q,
    output logic            byte_valid,
    output logic      [7:0] byte_data
);
    initial
    begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end
    // Held until an edge where ready was high
    task automatic put(input logic [7:0] b);
        logic ok;
        byte_valid <= 1'b1;
        byte_data <= b;
        do
        begin
            @(negedge clk_sys);
            ok = byte_ready;
            @(posedge clk_sys);
        end
        while (!ok);
    endtask
    // Call just after a rising edge
    task automatic send(input logic [13:0] ai, input logic [1:0] mk, input logic [13:0] aq);
        if (use_i)
        begin
            put({mk, ai[13:8]});
            put(ai[7:0]);
        end
        if (use_q)
        begin
            put({2'h0, aq[13:8]});
            put(aq[7:0]);
        end
        byte_valid <= 1'b0;
        byte_data <= ~byte_data; // Released bus shows no stale byte
        @(posedge clk_sys);
    endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import iqu_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        use_i = 1'b1;
    logic        use_q = 1'b1;
    logic        sample_ready = 1'b0;
    logic        byte_valid;
    logic        byte_ready;
    logic        sample_strobe;
    logic        marker1;
    logic        marker2;
    logic [7:0]  byte_data;
    logic [13:0] dac_i;
    logic [13:0] dac_q;
    int          fail_count = 0;
    int          samples_checked = 0;
    logic        fill_done = 1'b0;
    always #10 clk_sys = ~clk_sys;
    iqu_host_model iqu_host_model_i (.clk_sys(clk_sys), .byte_ready(byte_ready),
        .use_i(use_i), .use_q(use_q), .byte_valid(byte_valid), .byte_data(byte_data));
    iqu_unpacker iqu_unpacker_i (.clk_sys(clk_sys), .rst(rst), .byte_data(byte_data),
        .byte_valid(byte_valid), .byte_ready(byte_ready), .i_present(use_i),
        .q_present(use_q), .sample_ready(sample_ready), .sample_strobe(sample_strobe),
        .dac_i(dac_i), .dac_q(dac_q), .marker1(marker1), .marker2(marker2));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic expect_out(input logic [13:0] ai, input logic [1:0] mk, input logic [13:0] aq);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (sample_strobe !== 1'b1 && n < 40);
        check("strobe", {15'h0, sample_strobe}, 16'h1);
        check("dac_i", {2'h0, dac_i}, {2'h0, ai});
        check("dac_q", {2'h0, dac_q}, {2'h0, aq});
        check("markers", {14'h0, marker2, marker1}, {14'h0, mk});
    endtask
    task automatic scen_codes();
        logic [13:0] amp [4] = '{IQU_CODE_NEG_FS, IQU_CODE_ZERO, IQU_CODE_POS_FS, 14'h1555};
        @(posedge clk_sys);
        sample_ready <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_sys);
            iqu_host_model_i.send(amp[k], 2'(k), ~amp[k]);
            expect_out(amp[k], 2'(k), ~amp[k]);
        end
    endtask
    task automatic scen_fill();
        int n;
        @(posedge clk_sys);
        sample_ready <= 1'b0;
        fork
            begin
                for (int k = 0; k < 16; k++)
                    iqu_host_model_i.send(14'(k * 1021), 2'(k), 14'(16383 - k));
                fill_done = 1'b1;
            end
        join_none
        n = 0;
        while (byte_ready !== 1'b0 && n < 300)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("full", {15'h0, byte_ready}, 16'h0);
        repeat (5) @(negedge clk_sys);
        check("stall", {15'h0, byte_ready | sample_strobe}, 16'h0);
        @(posedge clk_sys);
        sample_ready <= 1'b1;
        for (int k = 0; k < 16; k++)
            expect_out(14'(k * 1021), 2'(k), 14'(16383 - k));
        n = 0;
        while (fill_done !== 1'b1 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("fill_done", {15'h0, fill_done}, 16'h1);
    endtask
    task automatic scen_absent();
        @(posedge clk_sys);
        use_q <= 1'b0;
        @(posedge clk_sys);
        iqu_host_model_i.send(14'h0abc, 2'h3, 14'h0);
        expect_out(14'h0abc, 2'h3, IQU_CODE_ZERO);
        @(posedge clk_sys);
        use_i <= 1'b0;
        use_q <= 1'b1;
        @(posedge clk_sys);
        iqu_host_model_i.send(14'h0, 2'h0, 14'h1234);
        expect_out(IQU_CODE_ZERO, 2'h0, 14'h1234);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        scen_codes();
        scen_fill();
        scen_absent();
        report_and_stop();
    end
endmodule
